// >>> rtl/tsas_map.svh
// Purpose: constants of the touch sense accumulate and scan block
// Assumes: included by bare name from rtl files
// Notes: What this block does list follows
// What this block does
// - three-bit sample count field selects 1, 4, 8, 16, 32 or 64 summed samples
// - after the last sample the sum is divided by the count into result registers
// - accumulation off: done interrupt after every conversion; selector kept without scan
// - accumulation on: done interrupt only after all programmed conversions are averaged
// - no accumulation: greater-than interrupt when result strictly exceeds threshold
// - accumulation on: greater-than uses averaged result, fired after the full set
// - auto-scan: result above threshold raises greater-than and halts the scan
// - auto-scan: above threshold keeps the selector on the current channel
// - auto-scan: not above threshold advances the selector by one
// - auto-scan: after passing the scan end channel the selector wraps to start
// - selector codes 0-7 pick port 0 pins, 8-13 port 1 pins 0-5, 14-15 reserved
// - selector code 12 is usable only on the larger 24-pin package
// - selector register resets to zero, choosing port 0 pin 0
`ifndef TSAS_MAP_SVH
`define TSAS_MAP_SVH
`define TSAS_CHSEL_ADDR 8'hab
`define TSAS_CHSEL_RESET 8'h00
`define TSAS_CH_LSB 0
`define TSAS_CH_MSB 3
`define TSAS_CH_COUNT 4'he
`define TSAS_CH_PKG24 4'hc
`define TSAS_DATA_W 16
`define TSAS_ACC_W 22
`define TSAS_CNT_W 7
`define TSAS_CNT_MAX 7'h40
`endif

// >>> rtl/tsas_pkg.sv
// Purpose: shared types of the touch sense accumulate and scan block
// Assumes: nothing
// Notes: constants live in tsas_map.svh
package tsas_pkg;
  typedef enum logic [1:0] {
    TSAS_IDLE = 2'b00,
    TSAS_REQ = 2'b01,
    TSAS_WAIT = 2'b10,
    TSAS_DONE = 2'b11
  } tsas_state_t;
  // sample count selector codes
  typedef enum logic [2:0] {
    TSAS_ACU_1 = 3'h0,
    TSAS_ACU_4 = 3'h1,
    TSAS_ACU_8 = 3'h2,
    TSAS_ACU_16 = 3'h3,
    TSAS_ACU_32 = 3'h4,
    TSAS_ACU_64 = 3'h5
  } tsas_acu_t;
  typedef logic [3:0] tsas_chan_t;
endpackage : tsas_pkg

// >>> rtl/tsas_avg.sv
// Purpose: sample target and average of an accumulated sum
// Assumes: counts are powers of two, so the divide is a shift
// Notes: codes 6 and 7 act as 64 samples
`timescale 1ns/1ps
`default_nettype none
`include "tsas_map.svh"
module tsas_avg #(
  parameter int ACC_W = `TSAS_ACC_W,
  parameter int DATA_W = `TSAS_DATA_W
) (
  input wire logic [2:0] acu,
  input wire logic [ACC_W-1:0] sum,
  output logic [`TSAS_CNT_W-1:0] target,
  output logic [DATA_W-1:0] quotient
);
  logic [2:0] shift;
  logic [ACC_W-1:0] shifted;
  // code to shift amount: 1,4,8,16,32,64 samples
  always_comb begin
    unique case (acu)
      3'h0: shift = 3'h0;
      3'h1: shift = 3'h2;
      3'h2: shift = 3'h3;
      3'h3: shift = 3'h4;
      3'h4: shift = 3'h5;
      default: shift = 3'h6;
    endcase
    target = `TSAS_CNT_W'(`TSAS_CNT_W'(1) << shift);
    shifted = sum >> shift;
    quotient = shifted[DATA_W-1:0];
  end
endmodule : tsas_avg
`default_nettype wire

// >>> rtl/tsas_top.sv
// Purpose: sequencing, accumulation, threshold compare and auto-scan of touch sensing
// Assumes: front end runs on clk; conv_done is a one-cycle pulse with conv_data valid
// Notes: only the channel selector sits on the special function register port
`timescale 1ns/1ps
`default_nettype none
`include "tsas_map.svh"
module tsas_top #(
  parameter bit PKG_24PIN = 1'b1,
  parameter int DATA_W = `TSAS_DATA_W,
  parameter int ACC_W = `TSAS_ACC_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic start,
  input wire logic auto_scan_enable,
  input wire logic [2:0] sample_count_select,
  input wire logic [7:0] threshold_high,
  input wire logic [7:0] threshold_low,
  input wire tsas_pkg::tsas_chan_t scan_start_channel,
  input wire tsas_pkg::tsas_chan_t scan_end_channel,
  output logic conv_req,
  output tsas_pkg::tsas_chan_t channel_selector,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  output logic [7:0] result_high,
  output logic [7:0] result_low,
  output logic conversion_done_irq,
  output logic greater_than_irq,
  output logic channel_invalid,
  output logic busy
);
  import tsas_pkg::*;

  tsas_state_t state;
  tsas_state_t next_state;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [`TSAS_CNT_W-1:0] cnt;
  logic [`TSAS_CNT_W-1:0] next_cnt;
  logic [`TSAS_CNT_W-1:0] target;
  logic [DATA_W-1:0] avg;
  tsas_chan_t next_channel;
  tsas_chan_t scan_next;
  logic [7:0] next_result_high;
  logic [7:0] next_result_low;
  logic next_done_irq;
  logic next_gt_irq;
  logic next_conv_req;
  logic sel_wr;
  logic cur_valid;
  logic scan_valid;
  logic above;

  // divide-by-count and sample target
  tsas_avg #(
    .ACC_W(ACC_W),
    .DATA_W(DATA_W)
  ) u_avg (
    .acu(sample_count_select),
    .sum(acc),
    .target(target),
    .quotient(avg)
  );

  // channel code legality and scan successor
  always_comb begin
    cur_valid = (channel_selector < `TSAS_CH_COUNT) &&
      (PKG_24PIN || channel_selector != `TSAS_CH_PKG24);
    if (channel_selector == scan_end_channel) begin
      scan_next = scan_start_channel;
    end else begin
      scan_next = channel_selector + 4'h1;
    end
    scan_valid = (scan_next < `TSAS_CH_COUNT) &&
      (PKG_24PIN || scan_next != `TSAS_CH_PKG24);
    above = avg > {threshold_high, threshold_low};
    sel_wr = sfr_we && sfr_addr == `TSAS_CHSEL_ADDR;
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    next_conv_req = 1'b0;
    unique case (state)
      TSAS_IDLE: begin
        if (start && cur_valid && !sel_wr) begin
          next_state = TSAS_REQ;
          next_conv_req = 1'b1;
        end
      end
      TSAS_REQ: begin
        next_state = TSAS_WAIT;
      end
      TSAS_WAIT: begin
        if (conv_done) begin
          if (cnt + 7'h1 >= target) begin
            next_state = TSAS_DONE;
          end else begin
            next_state = TSAS_REQ;
            next_conv_req = 1'b1;
          end
        end
      end
      TSAS_DONE: begin
        next_state = TSAS_IDLE;
        if (auto_scan_enable && !above && scan_valid && !sel_wr) begin
          next_state = TSAS_REQ;
          next_conv_req = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= TSAS_IDLE;
      conv_req <= 1'b0;
    end else begin
      state <= next_state;
      conv_req <= next_conv_req;
    end
  end

  // accumulator and sample counter
  always_comb begin
    next_acc = acc;
    next_cnt = cnt;
    if (state == TSAS_WAIT && conv_done) begin
      next_acc = acc + ACC_W'(conv_data);
      next_cnt = cnt + 7'h1;
    end else if (state == TSAS_DONE || state == TSAS_IDLE) begin
      next_acc = '0;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= '0;
      cnt <= '0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
    end
  end

  // results and interrupt pulses
  always_comb begin
    next_result_high = result_high;
    next_result_low = result_low;
    next_done_irq = 1'b0;
    next_gt_irq = 1'b0;
    if (state == TSAS_DONE) begin
      next_result_high = avg[15:8];
      next_result_low = avg[7:0];
      next_done_irq = 1'b1;
      next_gt_irq = above;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_high <= 8'h00;
      result_low <= 8'h00;
      conversion_done_irq <= 1'b0;
      greater_than_irq <= 1'b0;
    end else begin
      result_high <= next_result_high;
      result_low <= next_result_low;
      conversion_done_irq <= next_done_irq;
      greater_than_irq <= next_gt_irq;
    end
  end

  // channel selector: software write wins, scan advances only when not above threshold
  always_comb begin
    next_channel = channel_selector;
    if (sel_wr) begin
      next_channel = sfr_wdata[`TSAS_CH_MSB:`TSAS_CH_LSB];
    end else if (state == TSAS_DONE && auto_scan_enable && !above) begin
      next_channel = scan_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      channel_selector <= 4'(`TSAS_CHSEL_RESET);
    end else begin
      channel_selector <= next_channel;
    end
  end

  // status and register read data
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= `TSAS_CHSEL_RESET;
      channel_invalid <= 1'b0;
      busy <= 1'b0;
    end else begin
      sfr_rdata <= {4'h0, next_channel};
      channel_invalid <= !((next_channel < `TSAS_CH_COUNT) &&
        (PKG_24PIN || next_channel != `TSAS_CH_PKG24));
      busy <= next_state != TSAS_IDLE;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic [`TSAS_CNT_W-1:0] req_seen;
  always_ff @(posedge clk) begin
    if (srst || state == TSAS_IDLE || state == TSAS_DONE) begin
      req_seen <= '0;
    end else if (conv_req) begin
      req_seen <= req_seen + 7'h1;
    end
  end

  count_sel_a: assert property (
    state == TSAS_DONE |-> cnt == target)
    else $error("result written with wrong sample count");
  avg_write_a: assert property (
    state == TSAS_DONE |=> {result_high, result_low} == $past(avg))
    else $error("result is not the averaged sum");
  single_done_a: assert property (
    sample_count_select == 3'h0 && state == TSAS_WAIT && conv_done
      ##1 sample_count_select == 3'h0 |=> conversion_done_irq)
    else $error("single conversion did not signal done");
  multi_done_a: assert property (
    conversion_done_irq |-> $past(req_seen, 2) == $past(target, 2))
    else $error("done before all conversions");
  gt_fire_a: assert property (
    greater_than_irq |-> conversion_done_irq &&
      {result_high, result_low} > $past({threshold_high, threshold_low}))
    else $error("greater-than without exceeding threshold");
  scan_halt_a: assert property (
    greater_than_irq && $past(auto_scan_enable) && !$past(sel_wr) |-> !busy)
    else $error("scan kept running after a touch");
  scan_keep_a: assert property (
    state == TSAS_DONE && above && !sel_wr |=> $stable(channel_selector))
    else $error("selector moved after a touch");
  scan_step_a: assert property (
    state == TSAS_DONE && auto_scan_enable && !above && !sel_wr &&
      channel_selector != scan_end_channel
      |=> channel_selector == $past(channel_selector) + 4'h1)
    else $error("selector did not advance");
  scan_wrap_a: assert property (
    state == TSAS_DONE && auto_scan_enable && !above && !sel_wr &&
      channel_selector == scan_end_channel |=> channel_selector == $past(scan_start_channel))
    else $error("selector did not wrap");
  rsvd_zero_a: assert property (
    sfr_rdata[7:4] == 4'h0)
    else $error("reserved selector bits not zero");
  no_bad_start_a: assert property (
    state == TSAS_IDLE && !cur_valid |=> !conv_req)
    else $error("conversion started on reserved channel");

  // flags, selector mirror, accumulator clear and result hold
  acc_clear_a: assert property (
    state == TSAS_DONE |=> acc == '0 && cnt == '0)
    else $error("accumulator not cleared after a result");
  gt_single_a: assert property (
    state == TSAS_DONE && sample_count_select == 3'h0 &&
      avg > {threshold_high, threshold_low} |=> greater_than_irq)
    else $error("greater-than missing after single conversion");
  keep_sel_a: assert property (
    state == TSAS_DONE && !auto_scan_enable && !sel_wr |=> $stable(channel_selector))
    else $error("selector moved without auto-scan");
  invalid_flag_a: assert property (
    channel_invalid == !((channel_selector < `TSAS_CH_COUNT) &&
      (PKG_24PIN || channel_selector != `TSAS_CH_PKG24)))
    else $error("invalid channel flag wrong");
  rdata_mirror_a: assert property (
    sfr_rdata == {4'h0, channel_selector})
    else $error("register read differs from selector");
  done_pulse_a: assert property (
    conversion_done_irq |=> !conversion_done_irq)
    else $error("done interrupt longer than one cycle");
  idle_quiet_a: assert property (
    channel_invalid && state == TSAS_IDLE |=> !busy)
    else $error("sequencer left idle on invalid channel");
  busy_req_a: assert property (
    conv_req |-> busy)
    else $error("conversion requested while idle");
  result_hold_a: assert property (
    state != TSAS_DONE |=> $stable({result_high, result_low}))
    else $error("result changed outside a result write");

  scan_touch_c: cover property (
    auto_scan_enable && greater_than_irq);
  wrap_c: cover property (
    state == TSAS_DONE && auto_scan_enable && channel_selector == scan_end_channel);
  avg64_c: cover property (
    sample_count_select == 3'h5 && conversion_done_irq);
  above_single_c: cover property (
    sample_count_select == 3'h0 && greater_than_irq);
  rsvd_start_c: cover property (
    state == TSAS_IDLE && start && !cur_valid);
endmodule : tsas_top
`default_nettype wire

// >>> tb/tsas_front.sv
// Purpose: behavioural touch front end answering conversion requests
// Assumes: one answer per request, after 1 to 4 cycles
// Notes: top nibble of each value is the channel code; data idles inverted
`timescale 1ns/1ps
`default_nettype none
module tsas_front (
  input wire logic clk,
  input wire logic conv_req,
  input wire tsas_pkg::tsas_chan_t chan,
  output logic conv_done,
  output logic [15:0] conv_data
);
  import tsas_pkg::*;
  int wait_n;
  logic [15:0] last;
  // answer each request after a random wait, then drop done and drive the inverted data
  initial begin
    conv_done = 1'b0;
    conv_data = 16'h0000;
    forever begin
      @(posedge clk);
      if (conv_req === 1'b1) begin
        wait_n = $urandom_range(3, 0);
        repeat (wait_n) @(posedge clk);
        #1;
        last = {chan, 12'($urandom)};
        conv_done = 1'b1;
        conv_data = last;
        @(posedge clk);
        #1;
        conv_done = 1'b0;
        conv_data = ~last;
      end
    end
  end
endmodule : tsas_front
`default_nettype wire

// >>> tb/tb_touch_sense_accumulate_scan.sv
// Purpose: self-checking bench for the touch accumulate and scan block
// Assumes: front end model on the conversion handshake
// Notes: a reference model averages the samples seen on the handshake
`timescale 1ns/1ps
`default_nettype none
`define TSAS_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_touch_sense_accumulate_scan;
  import tsas_pkg::*;
  logic clk, srst, sfr_we, start, auto_scan_enable, conv_req, conv_done, busy;
  logic conversion_done_irq, greater_than_irq, channel_invalid;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, threshold_high, threshold_low;
  logic [7:0] result_high, result_low;
  logic [2:0] sample_count_select;
  logic [15:0] conv_data, avg, thr;
  tsas_chan_t scan_start_channel, scan_end_channel, channel_selector, cur, nxt;
  int failures = 0;
  int comparisons = 0;
  int n_res = 0;
  int ch;
  int q[$];
  tsas_top dut (.clk, .srst, .sfr_addr, .sfr_we, .sfr_wdata, .sfr_rdata, .start,
    .auto_scan_enable, .sample_count_select, .threshold_high, .threshold_low,
    .scan_start_channel, .scan_end_channel, .conv_req, .channel_selector, .conv_done,
    .conv_data, .result_high, .result_low, .conversion_done_irq, .greater_than_irq,
    .channel_invalid, .busy);
  tsas_front front (.clk, .conv_req, .chan(channel_selector), .conv_done, .conv_data);
  // samples summed per result for each count code
  function automatic int tgt(input logic [2:0] c);
    return (c == 3'h0) ? 1 : (c > 3'h4) ? 64 : (2 << c);
  endfunction : tgt
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    tick(1);
    sfr_we = 1'b0;
  endtask : sfr_write
  task automatic pulse_start();
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask : pulse_start
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // reference model: collect samples and predict each result
  always @(posedge clk) begin
    if (conv_done === 1'b1) begin
      q.push_back(conv_data);
      cur = channel_selector;
    end
    if (conversion_done_irq === 1'b1) begin
      `TSAS_CHK(q.size(), tgt(sample_count_select))
      avg = 16'(q.sum() / tgt(sample_count_select));
      thr = {threshold_high, threshold_low};
      `TSAS_CHK({result_high, result_low}, avg)
      `TSAS_CHK(greater_than_irq, avg > thr)
      nxt = cur;
      if (auto_scan_enable && !(avg > thr)) begin
        nxt = (cur == scan_end_channel) ? scan_start_channel : cur + 4'h1;
      end
      `TSAS_CHK(channel_selector, nxt)
      q.delete();
      n_res++;
    end
  end
  // watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {srst, sfr_we, start, auto_scan_enable} = 4'h8;
    {sfr_addr, sfr_wdata, threshold_high, threshold_low} = 32'h0;
    sample_count_select = 3'h0;
    scan_start_channel = 4'h0;
    scan_end_channel = 4'h0;
    void'($urandom(78120));
    tick(3);
    srst = 1'b0;
    `TSAS_CHK(sfr_rdata, 8'h00)
    `TSAS_CHK(channel_selector, 4'h0)
    sfr_write(8'hab, 8'hf3);
    `TSAS_CHK(sfr_rdata, 8'h03)
    tick(1);
    sfr_write(8'haa, 8'h07);
    `TSAS_CHK(channel_selector, 4'h3)
    // reserved codes refuse to start
    for (int c = 14; c < 16; c++) begin
      sfr_write(8'hab, 8'(c));
      tick(1);
      `TSAS_CHK(channel_invalid, 1'b1)
      pulse_start();
      `TSAS_CHK(conv_req, 1'b0)
      `TSAS_CHK(busy, 1'b0)
    end
    // every count code on a random channel, no scan
    for (int c = 0; c < 8; c++) begin
      ch = $urandom_range(13, 0);
      sfr_write(8'hab, 8'(ch));
      sample_count_select = 3'(c);
      {threshold_high, threshold_low} = {4'(ch), 12'($urandom)};
      pulse_start();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
      `TSAS_CHK(busy, 1'b0)
    end
    tick(1);
    `TSAS_CHK(n_res, 8)
    // auto-scan wraps, then stops on a touched channel
    sfr_write(8'hab, 8'h07);
    scan_start_channel = 4'h5;
    scan_end_channel = 4'h9;
    {threshold_high, threshold_low} = 16'hffff;
    sample_count_select = 3'h1;
    auto_scan_enable = 1'b1;
    pulse_start();
    for (int i = 0; i < 5000 && n_res < 16; i++) tick(1);
    `TSAS_CHK(n_res, 16)
    {threshold_high, threshold_low} = 16'h8fff;
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
    `TSAS_CHK(channel_selector, 4'h9)
    `TSAS_CHK(busy, 1'b0)
    tick(1);
    tally_and_finish();
  end
endmodule : tb_touch_sense_accumulate_scan
`default_nettype wire
